// *** verilog/rlw_map.svh ***
`ifndef RLW_MAP_SVH
`define RLW_MAP_SVH

// register indices; the byte address on the bus is four times the index
`define RLW_IDX_OPTION 8'h94
`define RLW_IDX_SOFTWARE_COMMAND_PORT 8'h97
`define RLW_IDX_AUXILIARY_CONTROL_TWO 8'hF7
`define RLW_IDX_AUXILIARY_CONTROL_ONE 8'hF8
`define RLW_IDX_CAUSE 8'hFC

// reset values
`define RLW_OPTION_RESET 8'h00
`define RLW_AUXILIARY_CONTROL_TWO_RESET 8'h06
`define RLW_AUXILIARY_CONTROL_ONE_RESET 8'h00
`define RLW_CFG_RESET 8'h00

// writable bit masks (reserved bits read as zero)
`define RLW_OPTION_MASK 8'hBC
`define RLW_AUXILIARY_CONTROL_TWO_MASK 8'hF7

// field positions
`define RLW_OPT_WDT_PERIOD_HI 5
`define RLW_OPT_WDT_PERIOD_LO 4
`define RLW_AUXILIARY_CONTROL_TWO_WDT_CTRL_HI 7
`define RLW_AUXILIARY_CONTROL_TWO_WDT_CTRL_LO 6
`define RLW_AUXILIARY_CONTROL_TWO_POWER_SAVE 5
`define RLW_AUXILIARY_CONTROL_TWO_MON_PD 0
`define RLW_AUXILIARY_CONTROL_ONE_WDT_CLEAR 7

// software reset key
`define RLW_SW_RESET_KEY 8'h56

// timing
`define RLW_PCLK_HZ 20000000
`define RLW_POR_HOLD_MS 40
`define RLW_POR_HOLD_CYCLES ((`RLW_POR_HOLD_MS * `RLW_PCLK_HZ) / 1000)
`define RLW_RST_HOLD_CYCLES 16
`define RLW_SRC_HZ 68000
`define RLW_WDT_LONG_MS 480
`define RLW_WDT_LONG_TICKS ((`RLW_WDT_LONG_MS * `RLW_SRC_HZ) / 1000)
`define RLW_PIN_MIN_SRC_TICKS 2

`endif

// *** verilog/rlw_pkg.sv ***
package rlw_pkg;

  typedef enum logic [2:0] {
    RLW_MODE_FAST,
    RLW_MODE_SLOW,
    RLW_MODE_IDLE,
    RLW_MODE_STOP,
    RLW_MODE_HALT
  } rlw_mode_t;

  // upper configuration byte as loaded from program memory
  typedef struct packed {
    logic protect;
    logic pin_reset_enable;
    logic [2:0] low_voltage_threshold_select;
    logic [2:0] other;
  } rlw_cfg_t;

  typedef struct packed {
    logic low_voltage_reset;
    logic watchdog_overflow_reset;
    logic software_reset_command;
    logic external_pin_reset;
    logic power_on;
  } rlw_cause_t;

endpackage

// *** verilog/rlw_sync3.sv ***
`timescale 1ns/1ns
// three-stage synchroniser; the output follows once the last two stages agree
module rlw_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= INIT;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // rlw_sync3

// *** verilog/rlw_reset_ctrl.sv ***
// Notes on behaviour
// RULE1 - the chip is reset by power-on, the external pin, a software command, watchdog overflow or low voltage.
// RULE2 - any reset returns every special function register to its default value; the code loads the cause register with the reset source instead.
// RULE3 - after power-on the reset is held 40 ms, then the configuration word is loaded before release.
// RULE4 - the pin reset is active low and a low of at least 2 slow RC periods is recognised as reset.
// RULE5 - the pin enable bit of the configuration word ignores the pin at 0 and honours it at 1.
// RULE6 - writing 56h to the software command register resets the chip, other values do not.
// RULE7 - the watchdog counts slow RC ticks in fast and slow modes and runs or stops in low-power modes by its enable.
// RULE8 - the watchdog period field selects 480, 240, 120 or 60 ms for codes 00 to 11.
// RULE9 - watchdog control 0x disables the reset, 10 allows it in fast and slow only, 11 in all modes.
// RULE10 - writing 1 to the watchdog clear bit zeroes the counter, the bit self-clears next cycle, and any reset zeroes it.
// RULE11 - the threshold field of the configuration word selects one of eight low-voltage trip levels.
// RULE12 - monitor power-down disables low-voltage reset, keeping power-on detection in fast, slow and idle only.
// RULE13 - power save leaves only power-on detection in idle and switches detection off in stop and halt.
// RULE14 - in fast and slow modes power save has no effect on the low-voltage reset.
// RULE15 - all sources merge into one internal reset that asserts at once and releases on the clock; the code asserts chip_rst_n on the next clock edge too.
`timescale 1ns/1ns
`include "rlw_map.svh"
module rlw_reset_ctrl import rlw_pkg::*; #(
  parameter int POR_HOLD_CYCLES = `RLW_POR_HOLD_CYCLES,
  parameter int WDT_LONG_TICKS = `RLW_WDT_LONG_TICKS,
  parameter int RST_HOLD_CYCLES = `RLW_RST_HOLD_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_pin_reset_n,
  input wire logic slow_internal_rc,
  input wire logic vcc_below_lvr,
  input wire logic vcc_below_por,
  input wire rlw_mode_t cpu_mode,
  output logic cfg_rd_req,
  input wire logic cfg_rd_valid,
  input wire logic [7:0] cfg_rd_data,
  output logic [2:0] low_voltage_threshold_select,
  output logic lvr_monitor_en,
  output logic por_monitor_en,
  output logic chip_rst_n
);

  typedef enum logic [1:0] {
    ST_POR_HOLD,
    ST_CFG_LOAD,
    ST_RUN,
    ST_RST_HOLD
  } rlw_state_t;

  localparam int CNT_W = $clog2(POR_HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(RST_HOLD_CYCLES - 1);
  localparam logic [15:0] WDT_LONG = 16'(WDT_LONG_TICKS);
  localparam logic [1:0] PIN_TICKS = 2'(`RLW_PIN_MIN_SRC_TICKS);

  // synchronised pins
  logic pin_n_s;
  logic src_s;
  logic lvr_s;
  logic por_s;

  rlw_sync3 #(
    .W(4),
    .INIT(4'b0001)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({slow_internal_rc, vcc_below_lvr, vcc_below_por, external_pin_reset_n}),
    .q({src_s, lvr_s, por_s, pin_n_s})
  );

  rlw_state_t state_reg;
  rlw_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  rlw_cfg_t cfg_reg;
  rlw_cause_t cause_reg;
  rlw_cause_t req;
  logic [7:0] option_reg;
  logic [7:0] auxiliary_control_two_reg;
  logic [7:0] auxiliary_control_one_reg;
  logic src_prev_reg;
  logic src_tick;
  logic [1:0] pin_cnt_reg;
  logic [15:0] wdt_cnt_reg;
  logic [15:0] wdt_limit;
  logic wdt_run;
  logic wdt_rst_en;
  logic wdt_ovf;
  logic run_mode;
  logic low_mode;
  logic lvr_on;
  logic por_on;
  logic sw_reset_hit;
  logic sfr_clear;
  logic setup;
  logic access;
  logic wr_en;
  logic [7:0] idx;
  logic addr_ok;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  // bus decode
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite;
  assign idx = paddr[9:2];
  assign wbyte = pwdata[7:0];
  assign sfr_clear = !chip_rst_n;

  always_comb begin
    addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    rd_byte = 8'h00;
    unique case (idx)
      `RLW_IDX_OPTION: rd_byte = option_reg;
      `RLW_IDX_SOFTWARE_COMMAND_PORT: rd_byte = 8'h00;
      `RLW_IDX_AUXILIARY_CONTROL_TWO: rd_byte = auxiliary_control_two_reg;
      `RLW_IDX_AUXILIARY_CONTROL_ONE: rd_byte = auxiliary_control_one_reg;
      `RLW_IDX_CAUSE: rd_byte = {3'b000, cause_reg};
      default: addr_ok = 1'b0;
    endcase
  end

  // answer one cycle after setup, so every access phase is one cycle long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= (addr_ok && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        pslverr <= !addr_ok;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  assign sw_reset_hit = wr_en && addr_ok && (idx == `RLW_IDX_SOFTWARE_COMMAND_PORT) && (wbyte == `RLW_SW_RESET_KEY); // see RULE6

  // registers return to defaults while the chip reset is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_reg <= `RLW_OPTION_RESET;
    end else if (sfr_clear) begin
      option_reg <= `RLW_OPTION_RESET; // see RULE2
    end else if (wr_en && addr_ok && idx == `RLW_IDX_OPTION) begin
      option_reg <= wbyte & `RLW_OPTION_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auxiliary_control_two_reg <= `RLW_AUXILIARY_CONTROL_TWO_RESET;
    end else if (sfr_clear) begin
      auxiliary_control_two_reg <= `RLW_AUXILIARY_CONTROL_TWO_RESET; // see RULE2
    end else if (wr_en && addr_ok && idx == `RLW_IDX_AUXILIARY_CONTROL_TWO) begin
      auxiliary_control_two_reg <= wbyte & `RLW_AUXILIARY_CONTROL_TWO_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auxiliary_control_one_reg <= `RLW_AUXILIARY_CONTROL_ONE_RESET;
    end else if (sfr_clear) begin
      auxiliary_control_one_reg <= `RLW_AUXILIARY_CONTROL_ONE_RESET; // see RULE2
    end else if (wr_en && addr_ok && idx == `RLW_IDX_AUXILIARY_CONTROL_ONE) begin
      auxiliary_control_one_reg <= wbyte;
    end else begin
      auxiliary_control_one_reg[`RLW_AUXILIARY_CONTROL_ONE_WDT_CLEAR] <= 1'b0; // see RULE10
    end
  end

  // operating mode and voltage monitor gating
  assign run_mode = (cpu_mode == RLW_MODE_FAST) || (cpu_mode == RLW_MODE_SLOW);
  assign low_mode = (cpu_mode == RLW_MODE_STOP) || (cpu_mode == RLW_MODE_HALT);

  always_comb begin
    // power save only matters outside fast and slow
    lvr_on = !auxiliary_control_two_reg[`RLW_AUXILIARY_CONTROL_TWO_MON_PD] && (run_mode || !auxiliary_control_two_reg[`RLW_AUXILIARY_CONTROL_TWO_POWER_SAVE]); // see RULE12, RULE13, RULE14
    // with the threshold monitor off, stop and halt drop detection entirely
    por_on = lvr_on || !low_mode; // see RULE12, RULE13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvr_monitor_en <= 1'b0;
      por_monitor_en <= 1'b0;
      low_voltage_threshold_select <= 3'b000;
    end else begin
      lvr_monitor_en <= lvr_on && chip_rst_n;
      por_monitor_en <= por_on || !chip_rst_n;
      // follows the loaded byte at the release edge so the monitor never sees a stale level after release
      if (state_reg == ST_CFG_LOAD && cfg_rd_valid) begin
        low_voltage_threshold_select <= cfg_rd_data[5:3]; // see RULE11
      end else begin
        low_voltage_threshold_select <= cfg_reg.low_voltage_threshold_select; // see RULE11
      end
    end
  end

  // slow RC tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_s;
    end
  end

  assign src_tick = src_s && !src_prev_reg;

  // pin must stay low for two slow RC rising edges before it counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cnt_reg <= 2'b00;
    end else if (pin_n_s) begin
      pin_cnt_reg <= 2'b00;
    end else if (src_tick && pin_cnt_reg != PIN_TICKS) begin
      pin_cnt_reg <= pin_cnt_reg + 2'b01; // see RULE4
    end
  end

  // watchdog
  assign wdt_limit = WDT_LONG >> option_reg[`RLW_OPT_WDT_PERIOD_HI:`RLW_OPT_WDT_PERIOD_LO]; // see RULE8
  assign wdt_run = run_mode || (auxiliary_control_two_reg[`RLW_AUXILIARY_CONTROL_TWO_WDT_CTRL_HI:`RLW_AUXILIARY_CONTROL_TWO_WDT_CTRL_LO] == 2'b11); // see RULE7
  assign wdt_rst_en = auxiliary_control_two_reg[`RLW_AUXILIARY_CONTROL_TWO_WDT_CTRL_HI] && (auxiliary_control_two_reg[`RLW_AUXILIARY_CONTROL_TWO_WDT_CTRL_LO] || run_mode); // see RULE9
  assign wdt_ovf = wdt_run && src_tick && (wdt_cnt_reg >= wdt_limit - 16'h0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_reg <= 16'h0000;
    end else if (sfr_clear || auxiliary_control_one_reg[`RLW_AUXILIARY_CONTROL_ONE_WDT_CLEAR] || wdt_ovf) begin
      wdt_cnt_reg <= 16'h0000; // see RULE10
    end else if (wdt_run && src_tick) begin
      wdt_cnt_reg <= wdt_cnt_reg + 16'h0001; // see RULE7
    end
  end

  // reset requests
  always_comb begin
    req.power_on = por_on && por_s;
    req.external_pin_reset = cfg_reg.pin_reset_enable && (pin_cnt_reg == PIN_TICKS); // see RULE4, RULE5
    req.software_reset_command = sw_reset_hit; // see RULE6
    req.watchdog_overflow_reset = wdt_ovf && wdt_rst_en; // see RULE9
    req.low_voltage_reset = lvr_on && lvr_s; // see RULE12
  end

  // sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_POR_HOLD: begin
        if (cnt_reg == POR_LAST) begin
          state_next = ST_CFG_LOAD; // see RULE3
        end
      end
      ST_CFG_LOAD: begin
        if (cfg_rd_valid) begin
          state_next = ST_RUN; // see RULE3
        end
      end
      ST_RUN: begin
        if (req.power_on) begin
          state_next = ST_POR_HOLD;
        end else if (req != '0) begin
          state_next = ST_RST_HOLD; // see RULE1
        end
      end
      ST_RST_HOLD: begin
        if (req.power_on) begin
          state_next = ST_POR_HOLD;
        end else if (cnt_reg >= HOLD_LAST && req == '0) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_POR_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      cnt_reg <= '0;
    end else if (state_reg == ST_POR_HOLD || (state_reg == ST_RST_HOLD && cnt_reg != HOLD_LAST)) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // configuration word is fetched only after power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `RLW_CFG_RESET;
      cfg_rd_req <= 1'b0;
    end else begin
      cfg_rd_req <= (state_next == ST_CFG_LOAD);
      if (state_reg == ST_CFG_LOAD && cfg_rd_valid) begin
        cfg_reg <= cfg_rd_data; // see RULE3
      end
    end
  end

  // asynchronous entry by presetn, synchronous release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_rst_n <= 1'b0;
    end else begin
      chip_rst_n <= (state_next == ST_RUN); // see RULE15
    end
  end

  // cause of the latest reset; survives internal resets so software can read it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= '0;
      cause_reg.power_on <= 1'b1;
    end else if (state_reg != ST_POR_HOLD && req.power_on) begin
      cause_reg <= '0;
      cause_reg.power_on <= 1'b1;
    end else if (state_reg == ST_RUN && req != '0) begin
      cause_reg <= req; // see RULE1
    end
  end

endmodule // rlw_reset_ctrl

// *** verification/rlw_reset_ctrl_asserts.sv ***
`timescale 1ns/1ns
module rlw_reset_ctrl_asserts import rlw_pkg::*; #(
  parameter int RST_HOLD_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rlw_mode_t cpu_mode,
  input wire logic cfg_rd_req,
  input wire logic cfg_rd_valid,
  input wire logic [2:0] low_voltage_threshold_select,
  input wire logic lvr_monitor_en,
  input wire logic por_monitor_en,
  input wire logic chip_rst_n
);
  int low_n;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // length of the current chip reset, judged at its release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_n <= 0;
    else low_n <= chip_rst_n ? 0 : low_n + 1;
  end
  chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  chk_err_access: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  chk_sw_reset: assert property (psel && penable && pready && pwrite && paddr == 12'h25C &&
    pwdata[7:0] == 8'h56 && chip_rst_n |-> ##[1:3] !chip_rst_n) else $error("key write gave no reset");
  chk_hold_min: assert property ($rose(chip_rst_n) |-> low_n >= RST_HOLD_CYCLES - 1)
    else $error("chip reset too short");
  chk_cfg_release: assert property (cfg_rd_req && cfg_rd_valid |=> chip_rst_n && !cfg_rd_req)
    else $error("no release after config byte");
  chk_cfg_waits: assert property (cfg_rd_req && !cfg_rd_valid |=> cfg_rd_req)
    else $error("config request dropped");
  chk_thr_kept: assert property (chip_rst_n && $past(chip_rst_n) |-> $stable(low_voltage_threshold_select))
    else $error("threshold changed while running");
  chk_por_awake: assert property (!(cpu_mode inside {RLW_MODE_STOP, RLW_MODE_HALT}) |=> por_monitor_en)
    else $error("power-on detector off while awake");
  chk_lvr_por: assert property (lvr_monitor_en |-> por_monitor_en)
    else $error("threshold monitor on without detector");
endmodule // rlw_reset_ctrl_asserts
bind rlw_reset_ctrl rlw_reset_ctrl_asserts #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_mode, .cfg_rd_req,
  .cfg_rd_valid, .low_voltage_threshold_select, .lvr_monitor_en, .por_monitor_en, .chip_rst_n);

// *** verification/rlw_far_side.sv ***
`timescale 1ns/1ns
module rlw_far_side (
  input wire logic pclk,
  input wire logic pin_low,
  input wire logic [5:0] supply,
  input wire logic [7:0] cfg_byte,
  input wire logic [3:0] cfg_wait,
  input wire logic cfg_rd_req,
  input wire logic [2:0] low_voltage_threshold_select,
  input wire logic lvr_monitor_en,
  input wire logic por_monitor_en,
  output logic cfg_rd_valid,
  output logic [7:0] cfg_rd_data,
  output logic external_pin_reset_n,
  output logic slow_internal_rc,
  output logic vcc_below_lvr,
  output logic vcc_below_por
);
  // supply and trip levels in tenths of a volt
  logic [5:0] trip [8] = '{6'h18, 6'h1B, 6'h1D, 6'h20, 6'h23, 6'h26, 6'h28, 6'h2B};
  logic [2:0] div = 3'h0;
  logic [3:0] wait_n = 4'h0;
  // the slow oscillator runs free, scaled to eight system clocks a period
  always @(posedge pclk) div <= div + 3'h1;
  assign slow_internal_rc = div[2];
  always @(posedge pclk) begin
    cfg_rd_valid <= 1'b0;
    if (!cfg_rd_req) wait_n <= 4'h0;
    else if (wait_n == cfg_wait && !cfg_rd_valid) cfg_rd_valid <= 1'b1;
    else wait_n <= wait_n + 4'h1;
  end
  // data bus shows garbage outside the valid cycle
  assign cfg_rd_data = cfg_rd_valid ? cfg_byte : ~cfg_byte;
  assign external_pin_reset_n = !pin_low;
  assign vcc_below_lvr = lvr_monitor_en && supply < trip[low_voltage_threshold_select];
  assign vcc_below_por = por_monitor_en && supply < 6'h17;
endmodule // rlw_far_side

// *** verification/test_reset_lvr_watchdog_ctrl.sv ***
`timescale 1ns/1ns
module test_reset_lvr_watchdog_ctrl import rlw_pkg::*; ();
  localparam int WT = 64;
  localparam logic [7:0] IX_RATE = 8'h94, IX_CMD = 8'h97, IX_CTL2 = 8'hF7, IX_CTL1 = 8'hF8, IX_CAUSE = 8'hFC;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin_low = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, cfg_rd_req, cfg_rd_valid, lvr_monitor_en, por_monitor_en, chip_rst_n;
  logic external_pin_reset_n, slow_internal_rc, vcc_below_lvr, vcc_below_por;
  logic [7:0] cfg_rd_data, cfg_byte = 8'h58;
  logic [2:0] low_voltage_threshold_select;
  logic [5:0] supply = 6'h32;
  logic [3:0] cfg_wait = 4'h2;
  logic [15:0] wd [6] = '{16'h0000, 16'h4000, 16'h8020, 16'h8040, 16'hC031, 16'hC011};
  logic [31:0] lv [8] = '{32'h00001E10, 32'h20011E10, 32'h01001E00, 32'h20021E00,
    32'h00021E10, 32'h01021401, 32'h01031400, 32'h20041400};
  rlw_mode_t cpu_mode = RLW_MODE_FAST;
  int fail_count = 0, total_checks = 0, cause_m = 0, seed = 32'h64F612AB, v, i, n, m;
  rlw_reset_ctrl #(.POR_HOLD_CYCLES(20), .WDT_LONG_TICKS(WT), .RST_HOLD_CYCLES(16)) i_dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_pin_reset_n,
    .slow_internal_rc, .vcc_below_lvr, .vcc_below_por, .cpu_mode, .cfg_rd_req, .cfg_rd_valid, .cfg_rd_data,
    .low_voltage_threshold_select, .lvr_monitor_en, .por_monitor_en, .chip_rst_n);
  rlw_far_side i_far (.pclk, .pin_low, .supply, .cfg_byte, .cfg_wait, .cfg_rd_req,
    .low_voltage_threshold_select, .lvr_monitor_en, .por_monitor_en, .cfg_rd_valid, .cfg_rd_data,
    .external_pin_reset_n, .slow_internal_rc, .vcc_below_lvr, .vcc_below_por);
  initial begin
    forever #25 pclk = ~pclk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] idx, input int exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask
  // far side back to quiet so the reset can end
  task wait_up();
    pin_low <= 1'b0;
    supply <= 6'h32;
    cpu_mode <= RLW_MODE_FAST;
    n = 0;
    while (chip_rst_n !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) begin
      fail_count++;
    end
    repeat (2) @(posedge pclk);
  endtask
  task expect_rst(input logic exp, input int lim, input int src);
    n = 0;
    while (chip_rst_n === 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    m = n;
    check({31'h0, ~chip_rst_n}, {31'h0, exp});
    // the cause register keeps only the latest source
    if (exp) cause_m = src;
    wait_up();
  endtask
  task power_up(input logic [7:0] b);
    cfg_byte <= b;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    cause_m = 1;
    wait_up();
    check({29'h0, low_voltage_threshold_select}, {29'h0, b[5:3]});
  endtask
  task wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
  initial begin
    power_up(8'h58);
    rd_chk(IX_RATE, 0);
    rd_chk(IX_CTL2, 6);
    rd_chk(IX_CTL1, 0);
    apb(1'b0, 8'h40, 8'h00);
    check({31'h0, err}, 1);
    v = $random(seed);
    apb(1'b1, IX_RATE, v[7:0]);
    apb(1'b1, IX_CTL2, v[15:8] & 8'h3F);
    rd_chk(IX_RATE, v[7:0] & 8'hBC);
    rd_chk(IX_CTL2, v[15:8] & 8'h37);
    apb(1'b1, IX_CMD, (v[23:16] == 8'h56) ? 8'h57 : v[23:16]);
    expect_rst(1'b0, 40, 0);
    apb(1'b1, IX_CMD, 8'h56);
    expect_rst(1'b1, 40, 4);
    rd_chk(IX_RATE, 0);
    rd_chk(IX_CTL2, 6);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, IX_RATE, 8'(i << 4));
      apb(1'b1, IX_CTL1, 8'h80);
      apb(1'b1, IX_CTL2, 8'h80);
      expect_rst(1'b1, 600, 8);
      check({31'h0, m > (WT >> i) * 8 - 17 && m < (WT >> i) * 8 + 17}, 1);
    end
    for (i = 0; i < 6; i++) begin
      apb(1'b1, IX_RATE, 8'h30);
      apb(1'b1, IX_CTL1, 8'h80);
      apb(1'b1, IX_CTL2, wd[i][15:8]);
      cpu_mode <= rlw_mode_t'(wd[i][6:4]);
      expect_rst(wd[i][0], 200, 8);
    end
    apb(1'b1, IX_RATE, 8'h30);
    apb(1'b1, IX_CTL1, 8'h80);
    apb(1'b1, IX_CTL2, 8'h80);
    repeat (8) begin
      apb(1'b1, IX_CTL1, 8'h80);
      repeat (20) @(posedge pclk);
    end
    expect_rst(1'b0, 1, 0);
    rd_chk(IX_CTL1, 0);
    apb(1'b1, IX_CTL2, 8'h00);
    pin_low <= 1'b1;
    repeat (17) @(posedge pclk);
    expect_rst(1'b1, 60, 2);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, IX_CTL2, lv[i][31:24]);
      cpu_mode <= rlw_mode_t'(lv[i][18:16]);
      repeat (4) @(posedge pclk);
      supply <= lv[i][13:8];
      expect_rst(lv[i][7:0] != 8'h00, 40, lv[i][7:0]);
    end
    rd_chk(IX_CAUSE, cause_m);
    power_up(8'h18);
    pin_low <= 1'b1;
    repeat (40) @(posedge pclk);
    expect_rst(1'b0, 1, 0);
    rd_chk(IX_CAUSE, cause_m);
    wrap_up();
  end
endmodule // test_reset_lvr_watchdog_ctrl
